// ---- rtl/otfs_frame_shaper.sv ----
// Frame sequencer, windowing and overlap-add output stage of the OFDM transmitter
// What this block does
// - Shape each header, sync and data symbol edge over eight samples with raised-cosine weights.
// - Samples between head and tail regions pass with unity weight.
// - Head weights rise 0 to 0.9619; tail weights are reversed.
// - Add weighted head of each symbol to weighted tail of the previous.
// - First symbol after the preamble overlaps the preamble tail.
// - Final symbol tail goes out weighted with nothing added.
// - Chosen tone map always keeps at least one group carrying data.
// - Masked carriers get no phase and zero amplitude in every mode.
// - Non-robust modes also obey the tone map; off carriers carry no payload.
// - Unused unmasked carriers get PN bits, as many as the modulation needs.
// - Filler PN reseeded to all ones per frame, stepped per filled carrier.
// - First PN bit of a symbol goes to the LSB, last to MSB.
// - Coherent data frames send inverted sync then sync before data.
// - Sync symbol is a tone symbol plus cyclic prefix and overlap, 278 net.
// - Sync symbol uses the preamble phase reference vector.
// - Inverted sync is the negated sync symbol, same length.
// - Pilots only in coherent data symbols; acknowledgements stay differential.
// - Preamble is 8 or 12 tone symbols, one closing unit, half unit.
// - In coherent frames, preamble and both sync symbols are sent 3 dB above data.
// - Twelve header symbols follow the preamble and flag coherent payload.
// - Pilot carriers are left out of the interleaved carrier set.
module otfs_frame_shaper (
  input  wire logic                           clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           start_i,
  input  wire otfs_pkg::otfs_cfg_s            cfg_i,
  input  wire logic                           in_valid_i,
  input  wire logic signed [otfs_pkg::SW-1:0] in_sample_i,
  output logic                                in_ready_o,
  output logic                                out_valid_o,
  output logic signed [otfs_pkg::SW-1:0]      out_sample_o,
  output otfs_pkg::otfs_state_e               sym_kind_o,
  output logic                                hdr_coherent_o,
  output logic                                frame_done_o,
  input  wire otfs_pkg::otfs_tone_s           tone_i,
  output otfs_pkg::otfs_tone_out_s            tone_o
);
  import otfs_pkg::*;
  otfs_state_e          st_d;
  otfs_cfg_s            cfg_q;
  otfs_tone_out_s       tone_d;
  logic [PW-1:0]        pos_q, len, tstart;
  logic [7:0]           cnt_q, nsym;
  logic [2:0]           fcnt_q, widx;
  logic signed [SW-1:0] tbuf_q [OVL];
  logic signed [SW-1:0] wsmp;
  logic                 tvld_q, acc, last_smp, last_sym, sym_end, grp_end;
  logic                 shaped, head, tail, boost, neg, fstart;

  // Length and count of the symbols in the current state
  always_comb begin
    len  = LEN_SYM;
    nsym = 8'h01;
    case (sym_kind_o)
      S_PRE: begin
        len  = LEN_FFT;
        nsym = cfg_q.long_pre ? NPRE_L : NPRE_S;
      end
      S_MSYNC: len = LEN_FFT;
      S_HALFM: len = LEN_HALF;
      S_CTRL:  nsym = NHDR;
      S_DATA:  nsym = cfg_q.n_data;
      default: ;
    endcase
  end

  // Sample position decode
  assign fstart   = (sym_kind_o == S_IDLE) && start_i;
  assign acc      = in_valid_i && in_ready_o;
  assign tstart   = len - PW'(OVL);
  assign last_smp = pos_q == (len - PW'(1));
  assign last_sym = cnt_q == (nsym - 8'h01);
  assign sym_end  = acc && last_smp;
  assign grp_end  = sym_end && last_sym;
  // every shaped symbol gets both edges
  assign shaped   = sym_kind_o inside {S_CTRL, S_INV_SYNC, S_SYNC, S_DATA};
  assign head     = shaped && (pos_q < PW'(OVL));
  // closing half unit gets a tail for the first symbol to overlap
  assign tail     = (shaped || (sym_kind_o == S_HALFM)) && (pos_q >= tstart);
  assign boost    = cfg_q.coherent && (sym_kind_o inside {S_PRE, S_MSYNC, S_HALFM, S_INV_SYNC, S_SYNC});
  // inverted sync is a sign flip of the sync stream
  assign neg      = sym_kind_o == S_INV_SYNC;
  assign widx     = head ? pos_q[2:0] : 3'(pos_q - tstart);

  otfs_window u_win (
    .smp_i   (in_sample_i),
    .idx_i   (widx),
    .head_i  (head),
    .tail_i  (tail),
    .boost_i (boost),
    .neg_i   (neg),
    .res_o   (wsmp)
  );

  // pilots only in coherent data frames
  otfs_pn_filler u_fill (
    .clk_i         (clk_i),
    .rst_b_i       (rst_b_i),
    .frame_start_i (fstart),
    .tone_map_i    (cfg_i.tone_map_group_field),
    .mod_i         (cfg_q.mod),
    .pilot_en_i    (cfg_q.coherent && !cfg_q.ack),
    .tone_i        (tone_i),
    .tone_o        (tone_d)
  );

  // Frame sequencing
  always_comb begin
    st_d = sym_kind_o;
    case (sym_kind_o)
      S_IDLE:     if (start_i) st_d = S_PRE;
      S_PRE:      if (grp_end) st_d = S_MSYNC;
      S_MSYNC:    if (grp_end) st_d = S_HALFM;
      S_HALFM:    if (grp_end) st_d = S_CTRL;
      S_CTRL: begin
        // sync pair only ahead of coherent data
        if (grp_end) begin
          if (cfg_q.ack || (cfg_q.n_data == 8'h00)) st_d = S_FLUSH;
          else if (cfg_q.coherent) st_d = S_INV_SYNC;
          else st_d = S_DATA;
        end
      end
      S_INV_SYNC: if (grp_end) st_d = S_SYNC;
      S_SYNC:     if (grp_end) st_d = S_DATA;
      S_DATA:     if (grp_end) st_d = S_FLUSH;
      S_FLUSH:    if (fcnt_q == 3'(OVL-1)) st_d = S_IDLE;
      default:    st_d = S_IDLE;
    endcase
  end

  // State and stream handshake; sym_kind_o also picks the phase reference upstream
  // sync states ask for the preamble reference vector
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sym_kind_o <= S_IDLE;
      in_ready_o <= 1'b0;
    end else begin
      sym_kind_o <= st_d;
      in_ready_o <= !(st_d inside {S_IDLE, S_FLUSH});
    end
  end

  // Frame settings held for the whole frame; start is ignored while busy
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_q          <= '0;
      hdr_coherent_o <= 1'b0;
    end else if (fstart) begin
      cfg_q          <= cfg_i;
      hdr_coherent_o <= cfg_i.coherent && !cfg_i.ack;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_q <= '0;
      cnt_q <= '0;
    end else if (st_d != sym_kind_o) begin
      pos_q <= '0;
      cnt_q <= '0;
    end else if (acc) begin
      pos_q <= last_smp ? '0 : pos_q + PW'(1);
      if (last_smp) cnt_q <= cnt_q + 8'h01;
    end
  end

  // Tail drain counter, runs only while flushing
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fcnt_q <= '0;
    end else if (sym_kind_o == S_FLUSH) begin
      fcnt_q <= fcnt_q + 3'h1;
    end else begin
      fcnt_q <= '0;
    end
  end

  // weighted tails wait here for the next head
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < OVL; i++) tbuf_q[i] <= '0;
      tvld_q <= 1'b0;
    end else begin
      if (acc && tail) tbuf_q[widx] <= wsmp;
      if (acc && tail && (widx == 3'(OVL-1))) begin
        tvld_q <= 1'b1;
      end else if ((acc && head && (widx == 3'(OVL-1))) || fstart || (sym_kind_o == S_FLUSH)) begin
        tvld_q <= 1'b0;
      end
    end
  end

  // Output stage; tail samples produce nothing until overlapped or flushed
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_valid_o  <= 1'b0;
      out_sample_o <= '0;
    end else if (sym_kind_o == S_FLUSH) begin
      out_valid_o  <= 1'b1;
      out_sample_o <= tbuf_q[fcnt_q];
    end else if (acc && !tail) begin
      out_valid_o  <= 1'b1;
      out_sample_o <= (head && tvld_q) ? sat((SW+2)'(wsmp) + (SW+2)'(tbuf_q[widx])) : wsmp;
    end else begin
      out_valid_o  <= 1'b0;
    end
  end

  // Registered tone result and end-of-frame pulse
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tone_o       <= '0;
      frame_done_o <= 1'b0;
    end else begin
      tone_o       <= tone_d;
      frame_done_o <= (sym_kind_o == S_FLUSH) && (st_d == S_IDLE);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_head_zero_wt: assert property (acc && sym_kind_o == S_CTRL && pos_q == '0 && tvld_q |=>
    out_valid_o && out_sample_o == $past(tbuf_q[0])) else $error("first head weight not zero");
  a_mid_unity: assert property (acc && sym_kind_o == S_DATA && !head && !tail |=>
    out_valid_o && out_sample_o == $past(in_sample_i)) else $error("middle sample altered");
  a_tail_held: assert property (acc && tail |=> !out_valid_o) else $error("tail sent early");
  a_pre_tail: assert property (acc && sym_kind_o == S_HALFM && last_smp |=> tvld_q)
    else $error("preamble tail lost");
  a_flush_tail: assert property (sym_kind_o == S_FLUSH && $past(sym_kind_o) != S_FLUSH |=>
    (out_valid_o && sym_kind_o == S_FLUSH)[*7] ##1 (out_valid_o && sym_kind_o == S_IDLE && frame_done_o))
    else $error("tail flush wrong");
  a_sync_order: assert property ($past(sym_kind_o) == S_CTRL && sym_kind_o != S_CTRL && cfg_q.coherent
    && !cfg_q.ack && cfg_q.n_data != 8'h00 |-> sym_kind_o == S_INV_SYNC ##[1:600] sym_kind_o == S_SYNC)
    else $error("sync pair missing");
  a_sync_len: assert property ($past(sym_kind_o) == S_SYNC && sym_kind_o != S_SYNC |->
    $past(pos_q) == LEN_SYM - PW'(1) && LEN_NET == 9'h116) else $error("sync length wrong");
  a_inv_negate: assert property (acc && neg && !head && !tail && in_sample_i == 16'sh1000 |=>
    out_sample_o == 16'she960) else $error("inverted sync not negated");
  a_gain_boost: assert property (acc && boost && !neg && !head && !tail && in_sample_i == 16'sh1000 |=>
    out_sample_o == 16'sh16a0) else $error("preamble gain wrong");
  a_pre_count: assert property ($past(sym_kind_o) == S_PRE && sym_kind_o != S_PRE |->
    $past(cnt_q) == (cfg_q.long_pre ? NPRE_L : NPRE_S) - 8'h01) else $error("preamble count wrong");
  a_hdr_count: assert property ($past(sym_kind_o) == S_CTRL && sym_kind_o != S_CTRL |->
    $past(cnt_q) == NHDR - 8'h01) else $error("header count wrong");
  a_ack_plain: assert property (sym_kind_o inside {S_INV_SYNC, S_SYNC} |-> !cfg_q.ack && cfg_q.coherent)
    else $error("sync in plain frame");
  a_sum_sat: assert property (acc && head && tvld_q && (wsmp[SW-1] == tbuf_q[widx][SW-1]) |=>
    out_sample_o[SW-1] == $past(wsmp[SW-1])) else $error("overlap sum wrapped");
endmodule // otfs_frame_shaper

// ---- rtl/otfs_pkg.sv ----
// Shared constants, types and helpers of the OFDM transmit frame shaper
package otfs_pkg;
  localparam int SW    = 16;  // Sample width
  localparam int WW    = 16;  // Window weight width, unsigned Q1.15
  localparam int WFRAC = 15;
  localparam int GFRAC = 14;  // Gain is unsigned Q2.14
  localparam int OVL   = 8;   // Boundary region length
  localparam int PW    = 9;   // Sample position width
  localparam int TMG   = 6;   // Tone map groups
  localparam int MBMAX = 4;   // Most bits per carrier
  localparam int PN_W  = 7;
  localparam int PN_TA = 6;   // Feedback taps of the filler generator
  localparam int PN_TB = 3;

  localparam logic [PW-1:0] LEN_FFT  = 9'h100;
  localparam logic [PW-1:0] LEN_CP   = 9'h01e;
  localparam logic [PW-1:0] LEN_HALF = 9'h080;
  localparam logic [PW-1:0] LEN_SYM  = LEN_FFT + LEN_CP;    // Samples taken per shaped symbol
  localparam logic [PW-1:0] LEN_NET  = LEN_SYM - PW'(OVL);  // Duration once overlapped
  localparam logic [7:0]    NPRE_S   = 8'h08;
  localparam logic [7:0]    NPRE_L   = 8'h0c;
  localparam logic [7:0]    NHDR     = 8'h0c;

  localparam logic [WW-1:0]     W_UNITY = 16'h8000;
  localparam logic [OVL*WW-1:0] W_HEAD  = {16'h7b1f, 16'h6d43, 16'h587d, 16'h4000,
                                           16'h2783, 16'h12bd, 16'h04e0, 16'h0000};
  localparam logic [WW-1:0]     G_UNITY = 16'h4000;
  localparam logic [WW-1:0]     G_3DB   = 16'h5a82;  // Square root of two
  localparam logic signed [SW-1:0] SMAX = 16'sh7fff;
  localparam logic signed [SW-1:0] SMIN = 16'sh8000;
  localparam logic [PN_W-1:0] PN_SEED   = 7'h7f;
  localparam logic [TMG-1:0]  MAP_ALL   = 6'h3f;
  localparam logic [TMG-1:0]  MAP_FIRST = 6'h01;

  typedef enum logic [3:0] {
    M_DBPSK, M_DQPSK, M_D8PSK, M_BPSK, M_QPSK, M_8PSK, M_QAM16, M_ROBUST, M_SROBUST
  } otfs_mod_e;

  // Gray coded along the frame up to flush; header to flush and flush to idle change two bits
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_PRE = 4'h1, S_MSYNC = 4'h3, S_HALFM = 4'h2, S_CTRL = 4'h6,
    S_INV_SYNC = 4'h7, S_SYNC = 4'h5, S_DATA = 4'h4, S_FLUSH = 4'hc
  } otfs_state_e;

  typedef struct packed {
    logic            coherent;
    logic            ack;
    logic            long_pre;
    logic [7:0]      n_data;
    otfs_mod_e       mod;
    logic [TMG-1:0]  tone_map_group_field;
  } otfs_cfg_s;

  typedef struct packed {
    logic             valid;
    logic             masked;
    logic             pilot;
    logic             data_sym;
    logic [2:0]       group;
    logic [MBMAX-1:0] bits;
  } otfs_tone_s;

  typedef struct packed {
    logic             valid;
    logic             zero_amp;
    logic             pilot;
    logic             take;
    logic [MBMAX-1:0] bits;
  } otfs_tone_out_s;

  function automatic logic [2:0] mod_bits(input otfs_mod_e m);
    case (m)
      M_DQPSK, M_QPSK: return 3'h2;
      M_D8PSK, M_8PSK: return 3'h3;
      M_QAM16:         return 3'h4;
      default:         return 3'h1;
    endcase
  endfunction

  function automatic logic robust(input otfs_mod_e m);
    return (m == M_ROBUST) || (m == M_SROBUST);
  endfunction

  // Tail weights are the head weights read backwards
  function automatic logic [WW-1:0] win_w(input logic [2:0] idx, input logic tail);
    logic [2:0] k;
    k = tail ? ~idx : idx;
    return W_HEAD[k*WW +: WW];
  endfunction

  function automatic logic signed [SW-1:0] sat(input logic signed [SW+1:0] v);
    if (v > SMAX) return SMAX;
    if (v < SMIN) return SMIN;
    return v[SW-1:0];
  endfunction
endpackage

// ---- rtl/otfs_window.sv ----
// Sample weighting: sign flip, gain boost and raised-cosine edge weight
module otfs_window (
  input  wire logic signed [otfs_pkg::SW-1:0] smp_i,
  input  wire logic [2:0]                     idx_i,
  input  wire logic                           head_i,
  input  wire logic                           tail_i,
  input  wire logic                           boost_i,
  input  wire logic                           neg_i,
  output logic signed [otfs_pkg::SW-1:0]      res_o
);
  import otfs_pkg::*;
  logic signed [SW:0]     n;
  logic signed [2*SW+1:0] pg;
  logic signed [2*SW+1:0] pw;
  logic signed [SW-1:0]   g;
  logic signed [SW-1:0]   r;
  logic [WW-1:0]          w;

  // Saturate after each stage so a boosted full-scale edge cannot wrap
  always_comb begin
    n     = (SW+1)'(smp_i);
    pg    = n * $signed({1'b0, boost_i ? G_3DB : G_UNITY});
    g     = sat(pg[SW+GFRAC+1:GFRAC]);
    w     = head_i ? win_w(idx_i, 1'b0) : (tail_i ? win_w(idx_i, 1'b1) : W_UNITY);
    pw    = g * $signed({1'b0, w});
    r     = sat(pw[SW+WFRAC+1:WFRAC]);
    // Negate last so the inverted sync is exactly minus the sync sample, rounding included
    res_o = neg_i ? sat(-(SW+2)'(r)) : r;
  end
endmodule // otfs_window

// ---- rtl/otfs_pn_filler.sv ----
// Tone map and tone mask stage that fills carriers without payload with PN bits
module otfs_pn_filler (
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     frame_start_i,
  input  wire logic [otfs_pkg::TMG-1:0] tone_map_i,
  input  wire otfs_pkg::otfs_mod_e      mod_i,
  input  wire logic                     pilot_en_i,
  input  wire otfs_pkg::otfs_tone_s     tone_i,
  output otfs_pkg::otfs_tone_out_s      tone_o
);
  import otfs_pkg::*;
  logic [PN_W-1:0]  pn_q, pn_d;
  logic [TMG-1:0]   map_q;
  logic [MBMAX-1:0] pnb;
  logic [2:0]       nb;
  logic             off_map, pilot, fill;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      map_q <= MAP_ALL;
    end else if (frame_start_i) begin
      map_q <= (tone_map_i == '0) ? MAP_FIRST : tone_map_i;
    end
  end

  // Carrier classification and PN substitution
  always_comb begin
    nb      = mod_bits(mod_i);
    pilot   = pilot_en_i && tone_i.pilot && tone_i.data_sym;
    off_map = !robust(mod_i) && !((tone_i.group < TMG) && map_q[tone_i.group]);
    fill    = tone_i.valid && !pilot && (tone_i.masked || off_map);
    pn_d    = pn_q;
    pnb     = '0;
    // one PN bit per tone bit
    for (int i = 0; i < MBMAX; i++) begin
      if (fill && (i < nb)) begin
        pnb[i] = pn_d[PN_TA] ^ pn_d[PN_TB];
        pn_d   = {pn_d[PN_W-2:0], pnb[i]};
      end
    end
    tone_o          = '0;
    tone_o.valid    = tone_i.valid;
    tone_o.pilot    = pilot;
    tone_o.zero_amp = tone_i.valid && tone_i.masked;
    tone_o.take     = tone_i.valid && !pilot && !tone_i.masked && !off_map;
    tone_o.bits     = tone_o.take ? tone_i.bits : (tone_i.masked ? '0 : pnb);
  end

  // seeded per frame, advanced per filled carrier
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pn_q <= PN_SEED;
    end else if (frame_start_i) begin
      pn_q <= PN_SEED;
    end else begin
      pn_q <= pn_d;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_pn_reload: assert property (frame_start_i |=> pn_q == PN_SEED) else $error("PN not reseeded");
  a_map_nonzero: assert property (map_q != '0) else $error("all groups dummy");
  a_mask_zero: assert property (tone_i.valid && tone_i.masked |-> tone_o.zero_amp && !tone_o.take && tone_o.bits == '0)
    else $error("masked carrier driven");
  a_pn_lsb_first: assert property (fill && !tone_i.masked |-> tone_o.bits[0] == (pn_q[PN_TA] ^ pn_q[PN_TB]))
    else $error("first PN bit not LSB");
  a_pn_step: assert property (fill && nb == 3'h1 && !frame_start_i |=>
    pn_q == {$past(pn_q[PN_W-2:0]), $past(pn_q[PN_TA] ^ pn_q[PN_TB])}) else $error("PN step wrong");
  a_robust_map: assert property (tone_i.valid && robust(mod_i) && !tone_i.masked && !pilot |-> tone_o.take)
    else $error("robust carrier used map");
  a_pilot_skip: assert property (pilot && !frame_start_i |=> $stable(pn_q)) else $error("pilot moved PN");
endmodule // otfs_pn_filler

// ---- verification/otfs_afe_model.sv ----
// Analog front end model: zero-order hold line driver that counts samples
module otfs_afe_model (
  input  wire logic                           clk_i,
  input  wire logic                           rst_b_i,
  input  wire logic                           valid_i,
  input  wire logic signed [otfs_pkg::SW-1:0] sample_i,
  output logic signed [otfs_pkg::SW-1:0]      line_o,
  output logic [31:0]                         count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import otfs_pkg::*;

  // Line keeps the last sample between updates, as a real DAC does
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_o  <= '0;
      count_o <= '0;
    end else if (valid_i) begin
      line_o  <= sample_i;
      count_o <= count_o + 32'h1;
    end
  end
endmodule // otfs_afe_model

// ---- verification/otfs_frame_shaper_tb.sv ----
// Self-checking bench of the transmit frame shaper with a front end model
module otfs_frame_shaper_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import otfs_pkg::*;

  logic               clk_i, rst_b_i, start_i, in_valid_i, in_ready_o, out_valid_o, hdr_coherent_o, frame_done_o;
  logic signed [15:0] in_sample_i, out_sample_o;
  otfs_cfg_s          cfg_i;
  otfs_state_e        sym_kind_o;
  otfs_tone_s         tone_i;
  otfs_tone_out_s     tone_o, te;
  logic [31:0]        seed = 32'h151f9a47, afe_cnt, nexp, r;
  logic [16:0]        smp_q[$], e;
  otfs_tone_out_s     tone_q[$];
  logic [6:0]         pn;
  bit                 quiet;
  int                 tail[8] = '{default: 0};
  int                 errors = 0, total_checks = 0, cycles = 0;

  otfs_frame_shaper uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .cfg_i(cfg_i),
    .in_valid_i(in_valid_i), .in_sample_i(in_sample_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
    .out_sample_o(out_sample_o), .sym_kind_o(sym_kind_o), .hdr_coherent_o(hdr_coherent_o),
    .frame_done_o(frame_done_o), .tone_i(tone_i), .tone_o(tone_o));
  otfs_afe_model afe (.clk_i(clk_i), .rst_b_i(rst_b_i), .valid_i(out_valid_o), .sample_i(out_sample_o),
    .line_o(), .count_o(afe_cnt));

  // Free running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (x !== g) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  // Saturate like the output stage, then note the expected sample
  task automatic push(input int v, input bit last);
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    smp_q.push_back({last, 16'(v)});
    nexp++;
  endtask

  // Boundary samples of plain symbols are full scale negative so weights show exactly
  task automatic send_sym(input otfs_state_e k, input int len, input bit hw, tw, bst, neg);
    logic signed [15:0] x;
    int p, wt;
    bit hd, tl, ok;
    for (int i = 0; i < len; i++) begin
      hd = hw && i < 8;
      tl = tw && i >= len - 8;
      // Boosted values step by 4096 so the gain and sign checks meet 0x1000
      if (bst) x = (hd || tl || quiet) ? 16'sh0 : 16'(int'(rnd() % 9) * 4096 - 16384);
      else x = (hd || tl) ? 16'sh8000 : 16'(rnd());
      wt = hd ? int'(W_HEAD[i*16 +: 16]) : tl ? int'(W_HEAD[(len-1-i)*16 +: 16]) : 32768;
      p = bst ? (x * 23170) >>> 14 : x;
      p = (p * wt) >>> 15;
      // negation comes after gain and weight
      p = neg ? -p : p;
      if (tl) tail[i-len+8] = p;
      else begin
        push(p + (hd ? tail[i] : 0), 1'b0);
        if (hd) tail[i] = 0;
      end
      do begin
        if (rnd() % 16 == 0) begin
          in_valid_i = 1'b0;
          in_sample_i = ~x;
          step();
        end
        in_valid_i = 1'b1;
        in_sample_i = x;
        ok = in_ready_o;
        if (ok) chk("kind", k, sym_kind_o);
        step();
      end while (!ok);
    end
  endtask

  task automatic frame(input otfs_cfg_s c);
    for (int t = 0; t < (c.long_pre ? 12 : 8); t++) send_sym(S_PRE, 256, 0, 0, c.coherent, 0);
    send_sym(S_MSYNC, 256, 0, 0, c.coherent, 0);
    send_sym(S_HALFM, 128, 0, 1, c.coherent, 0);
    repeat (12) send_sym(S_CTRL, 286, 1, 1, 0, 0);
    if (!c.ack && c.n_data != 8'h0) begin
      if (c.coherent) begin
        send_sym(S_INV_SYNC, 286, 1, 1, 1, 1);
        send_sym(S_SYNC, 286, 1, 1, 1, 0);
      end
      repeat (c.n_data) send_sym(S_DATA, 286, 1, 1, 0, 0);
    end
    in_valid_i = 1'b0;
    for (int j = 0; j < 8; j++) begin
      push(tail[j], j == 7);
      tail[j] = 0;
    end
    for (int n = 0; n < 60 && (sym_kind_o !== S_IDLE || smp_q.size() != 0); n++) step();
    chk("idle", S_IDLE, sym_kind_o);
    chk("ready", 32'h0, in_ready_o);
  endtask

  // Random carriers against a reference of map, mask, pilot and filler
  task automatic tones(input otfs_cfg_s c);
    otfs_tone_s t;
    otfs_tone_out_s o;
    logic [2:0] nb;
    logic [5:0] map;
    bit rob, b;
    map = (c.tone_map_group_field == 6'h0) ? MAP_FIRST : c.tone_map_group_field;
    rob = c.mod == M_ROBUST || c.mod == M_SROBUST;
    nb = (c.mod == M_DQPSK || c.mod == M_QPSK) ? 3'h2 : (c.mod == M_D8PSK || c.mod == M_8PSK) ? 3'h3
       : (c.mod == M_QAM16) ? 3'h4 : 3'h1;
    repeat (300) begin
      r = rnd();
      t = r[10:0];
      if (t.masked) t.pilot = 1'b0;
      t.bits = t.bits & 4'((1 << nb) - 1);
      o = '0;
      o.valid = t.valid;
      o.pilot = t.pilot && t.data_sym && c.coherent && !c.ack;
      if (t.masked || (!o.pilot && !rob && (t.group > 3'h5 || !map[t.group]))) begin
        o.zero_amp = t.masked;
        for (int j = 0; j < nb && t.valid; j++) begin
          b = pn[6] ^ pn[3];
          pn = {pn[5:0], b};
          o.bits[j] = b;
        end
        if (t.masked) o.bits = '0;
      end else if (!o.pilot) begin
        o.take = 1'b1;
        o.bits = t.bits;
      end
      tone_i = t;
      if (t.valid) tone_q.push_back(o);
      step();
    end
    tone_i = '0;
  endtask

  // Output watcher and run limit
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      final_report();
    end
    if (out_valid_o === 1'b1) begin
      if (smp_q.size() == 0) chk("spare sample", 32'h0, 32'h1);
      else begin
        e = smp_q.pop_front();
        chk("sample", e[15:0], $unsigned(out_sample_o));
        chk("done", e[16], frame_done_o);
      end
    end
    if (tone_o.valid === 1'b1) begin
      if (tone_q.size() == 0) chk("spare tone", 32'h0, 32'h1);
      else begin
        te = tone_q.pop_front();
        chk("tone", te, tone_o);
      end
    end
  end

  // Main sequence: refusal while idle, then one frame per modulation
  initial begin
    rst_b_i = 1'b0;
    start_i = 1'b0;
    in_valid_i = 1'b0;
    in_sample_i = '0;
    cfg_i = '0;
    tone_i = '0;
    nexp = '0;
    repeat (16) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    in_valid_i = 1'b1;
    in_sample_i = 16'sh1234;
    repeat (4) step();
    in_valid_i = 1'b0;
    for (int f = 0; f < 9; f++) begin
      r = rnd();
      cfg_i.coherent = f[0];
      cfg_i.long_pre = f[1];
      cfg_i.ack = (f == 5);
      cfg_i.n_data = (f == 4) ? 8'h0 : 8'(f % 2 + 1);
      cfg_i.mod = otfs_mod_e'(f);
      cfg_i.tone_map_group_field = (f == 0) ? 6'h0 : r[5:0];
      quiet = cfg_i.ack;
      start_i = 1'b1;
      step();
      start_i = 1'b0;
      pn = 7'h7f;
      chk("hdr flag", cfg_i.coherent && !cfg_i.ack, hdr_coherent_o);
      fork
        tones(cfg_i);
        frame(cfg_i);
      join
      chk("line count", nexp, afe_cnt);
    end
    final_report();
  end
endmodule // otfs_frame_shaper_tb
